// ===== common/ubsc_pkg.sv
// Purpose: Shared constants and types for the USB bus-state control pair.
// Assumes: One 100 MHz core clock for both ends.
// Notes: Times are held in microseconds and the cycle counts derived from them, except UBSC_EOP_CYC, which is set in cycles.
package ubsc_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned UBSC_CLK_MHZ = 100;
  localparam int unsigned UBSC_BUS_RESET_US = 2500;
  localparam int unsigned UBSC_BUS_RESET_CYC = UBSC_BUS_RESET_US * UBSC_CLK_MHZ;
  localparam int unsigned UBSC_SUSPEND_IDLE_US = 3000;
  localparam int unsigned UBSC_SUSPEND_IDLE_CYC = UBSC_SUSPEND_IDLE_US * UBSC_CLK_MHZ;
  // Latest point for full suspend; the device meets it by suspending at the idle count
  localparam int unsigned UBSC_SUSPEND_LATEST_US = 10000;
  localparam int unsigned UBSC_RESUME_DETECT_US = 1;
  localparam int unsigned UBSC_RESUME_DETECT_CYC = UBSC_RESUME_DETECT_US * UBSC_CLK_MHZ;
  localparam int unsigned UBSC_HOST_RESUME_US = 20000;
  localparam int unsigned UBSC_HOST_RESUME_CYC = UBSC_HOST_RESUME_US * UBSC_CLK_MHZ;
  localparam int unsigned UBSC_HOST_RESET_US = 10000;
  localparam int unsigned UBSC_HOST_RESET_CYC = UBSC_HOST_RESET_US * UBSC_CLK_MHZ;
  localparam int unsigned UBSC_KEEPALIVE_US = 1000;
  localparam int unsigned UBSC_KEEPALIVE_CYC = UBSC_KEEPALIVE_US * UBSC_CLK_MHZ;
  localparam int unsigned UBSC_EOP_CYC = 2;
  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [7:0] UBSC_ENADR_OFS = 8'h10;
  localparam logic [7:0] UBSC_FLGA_OFS = 8'h11;
  localparam logic [7:0] UBSC_FLGB_OFS = 8'h12;
  localparam logic [7:0] UBSC_CFG_OFS = 8'h13;
  localparam logic [7:0] UBSC_MSKA_OFS = 8'h14;
  localparam logic [7:0] UBSC_MSKB_OFS = 8'h15;
  localparam logic [7:0] UBSC_PDOWN_OFS = 8'h16;
  localparam logic [7:0] UBSC_REG_RST = 8'h00;
  localparam int UBSC_FUNC_EN_BIT = 7;
  localparam int UBSC_IDLE_FLAG_BIT = 2;
  localparam int UBSC_RESET_FLAG_BIT = 4;
  localparam int UBSC_WAKE_FLAG_BIT = 3;
  localparam int UBSC_LOW_POWER_BIT = 7;
  localparam int UBSC_REMOTE_WAKE_BIT = 6;
  localparam int UBSC_PULLUP_BIT = 3;
  localparam logic [7:0] UBSC_FLGA_IMPL = 8'h04;
  localparam logic [7:0] UBSC_FLGB_IMPL = 8'h18;
  localparam logic [7:0] UBSC_CFG_WMASK = 8'hf9;
  // ****************************************
  // Host controller register map
  // ****************************************
  localparam logic [7:0] UBSC_HCMD_OFS = 8'h00;
  localparam logic [7:0] UBSC_HSTAT_OFS = 8'h01;
  localparam logic [7:0] UBSC_HEVT_OFS = 8'h02;
  localparam logic [7:0] UBSC_HMSK_OFS = 8'h03;
  localparam int UBSC_HCMD_RESET_BIT = 0;
  localparam int UBSC_HCMD_SUSPEND_BIT = 1;
  localparam int UBSC_HCMD_RESUME_BIT = 2;
  localparam int UBSC_HEVT_RWAKE_BIT = 0;
  localparam int UBSC_HEVT_DONE_BIT = 1;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic {UBSC_DEV_ACTIVE, UBSC_DEV_SUSPENDED} ubsc_dev_state_t;
  typedef enum logic [1:0] {UBSC_H_RUN, UBSC_H_RESET, UBSC_H_QUIET, UBSC_H_RESUME} ubsc_host_state_t;
endpackage : ubsc_pkg

// ===== common/ubsc_link_if.sv
// Purpose: The two USB data lines between host and device.
// Assumes: Host drive wins over device drive; pull-up holds DP high otherwise.
// Notes: Lines are resolved from enables, no tri-state value is used.
`timescale 1ns/10ps
interface ubsc_link_if;
  logic host_dp_o;
  logic host_dp_oe;
  logic host_dm_o;
  logic host_dm_oe;
  logic dev_dp_o;
  logic dev_dp_oe;
  logic dev_dm_o;
  logic dev_dm_oe;
  logic dev_pullup_en;
  logic dp_line;
  logic dm_line;
  // Host pull-downs make an undriven line low unless the device pull-up is on
  assign dp_line = host_dp_oe ? host_dp_o : (dev_dp_oe ? dev_dp_o : dev_pullup_en);
  assign dm_line = host_dm_oe ? host_dm_o : (dev_dm_oe ? dev_dm_o : 1'b0);
  modport dev (input dp_line, input dm_line, output dev_dp_o, output dev_dp_oe, output dev_dm_o,
    output dev_dm_oe, output dev_pullup_en);
  modport host (input dp_line, input dm_line, output host_dp_o, output host_dp_oe, output host_dm_o,
    output host_dm_oe);
endinterface : ubsc_link_if

// ===== core/ubsc_device.sv
// Purpose: Device-side bus-state control: reset, suspend, resume, pull-up, CPU wake.
// Assumes: Line inputs are synchronous to i_core_clk; full-speed signalling only.
// Notes: Event flags clear by writing 0; writing 1 leaves a flag as it is.
`timescale 1ns/10ps
// What this block does
// - Function idle while enable bit 7 is 0
// - SE0 longer than 2.5 ms is reset
// - Reset sets flag B bit 4, write-0 clears
// - Firmware clears flags by whole-register write
// - Suspend control bit requests low-power state
// - Power-down wakes on interrupt, reset, resume
// - Drive resume only with both control bits
// - Host drives resume at least 20 ms
// - DP low (differential 0) resumes suspended device
// - Suspend after idle over 3 ms
// - Suspended device ignores all but resume and reset
// - Resume sets flag B bit 3
// - Suspend sets flag A bit 2
// - Config bit 3 connects DP pull-up
// - Remote wake drives DP low
// - Firmware floats DP and DM port pins
module ubsc_device
  import ubsc_pkg::*;
#(
  parameter int unsigned BUS_RESET_CYC = UBSC_BUS_RESET_CYC,
  parameter int unsigned SUSPEND_IDLE_CYC = UBSC_SUSPEND_IDLE_CYC,
  parameter int unsigned RESUME_DETECT_CYC = UBSC_RESUME_DETECT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  ubsc_link_if.dev link,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_cpu_power_down,
  output logic o_function_active,
  output logic o_suspended,
  output logic o_low_power,
  output logic [6:0] o_device_address
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] enadr;
    logic [7:0] flg_a;
    logic [7:0] flg_b;
    logic [7:0] cfg;
    logic [7:0] msk_a;
    logic [7:0] msk_b;
    logic pdown;
    ubsc_dev_state_t st;
    logic [31:0] se0_cnt;
    logic [31:0] idle_cnt;
    logic [31:0] k_cnt;
    logic rst_seen;
    logic [7:0] rdata;
  } ubsc_dev_regs_t;

  ubsc_dev_regs_t reg_q;
  ubsc_dev_regs_t reg_d;
  logic se0;
  logic jst;
  logic kst;
  logic ev_reset;
  logic ev_idle;
  logic ev_wake;
  logic drive_wake;
  logic irq_any;

  assign se0 = !link.dp_line && !link.dm_line;
  assign jst = link.dp_line && !link.dm_line;
  assign kst = !link.dp_line && link.dm_line;
  assign irq_any = |(reg_q.flg_a & reg_q.msk_a) || |(reg_q.flg_b & reg_q.msk_b);
  // Resume goes out only from suspend with both control bits set
  assign drive_wake = reg_q.enadr[UBSC_FUNC_EN_BIT] && reg_q.cfg[UBSC_LOW_POWER_BIT] &&
    reg_q.cfg[UBSC_REMOTE_WAKE_BIT] && (reg_q.st == UBSC_DEV_SUSPENDED);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    reg_d = reg_q;
    ev_reset = 1'b0;
    ev_idle = 1'b0;
    ev_wake = 1'b0;
    reg_d.rdata = 8'h00;
    if (!reg_q.enadr[UBSC_FUNC_EN_BIT]) begin
      reg_d.st = UBSC_DEV_ACTIVE;
      reg_d.se0_cnt = 32'h0;
      reg_d.idle_cnt = 32'h0;
      reg_d.k_cnt = 32'h0;
      reg_d.rst_seen = 1'b0;
    end else begin
      // Reset is seen in any state, so it also ends suspend
      if (se0) begin
        if (reg_q.se0_cnt < BUS_RESET_CYC) begin
          reg_d.se0_cnt = reg_q.se0_cnt + 32'h1;
        end else if (!reg_q.rst_seen) begin
          ev_reset = 1'b1;
          reg_d.rst_seen = 1'b1;
        end
      end else begin
        reg_d.se0_cnt = 32'h0;
        reg_d.rst_seen = 1'b0;
      end
      unique case (reg_q.st)
        UBSC_DEV_ACTIVE: begin
          reg_d.k_cnt = 32'h0;
          if (!jst) begin
            reg_d.idle_cnt = 32'h0;
          end else if (reg_q.idle_cnt < SUSPEND_IDLE_CYC) begin
            reg_d.idle_cnt = reg_q.idle_cnt + 32'h1;
          end else begin
            ev_idle = 1'b1;
            reg_d.st = UBSC_DEV_SUSPENDED;
            reg_d.idle_cnt = 32'h0;
          end
        end
        UBSC_DEV_SUSPENDED: begin
          // Only a host K wakes; our own remote-wake K must not count
          if (kst && !drive_wake) begin
            if (reg_q.k_cnt < RESUME_DETECT_CYC) begin
              reg_d.k_cnt = reg_q.k_cnt + 32'h1;
            end else begin
              ev_wake = 1'b1;
              reg_d.st = UBSC_DEV_ACTIVE;
              reg_d.k_cnt = 32'h0;
            end
          end else begin
            reg_d.k_cnt = 32'h0;
          end
        end
      endcase
      if (ev_reset) begin
        reg_d.st = UBSC_DEV_ACTIVE;
        reg_d.idle_cnt = 32'h0;
        reg_d.k_cnt = 32'h0;
      end
    end
    // Register writes; flag writes AND the data in, events OR in after so set wins
    if (i_wr) begin
      unique case (i_addr)
        UBSC_ENADR_OFS: reg_d.enadr = i_wdata;
        UBSC_FLGA_OFS: reg_d.flg_a = reg_q.flg_a & i_wdata & UBSC_FLGA_IMPL;
        UBSC_FLGB_OFS: reg_d.flg_b = reg_q.flg_b & i_wdata & UBSC_FLGB_IMPL;
        UBSC_CFG_OFS: reg_d.cfg = i_wdata & UBSC_CFG_WMASK;
        UBSC_MSKA_OFS: reg_d.msk_a = i_wdata & UBSC_FLGA_IMPL;
        UBSC_MSKB_OFS: reg_d.msk_b = i_wdata & UBSC_FLGB_IMPL;
        UBSC_PDOWN_OFS: reg_d.pdown = i_wdata[0];
        default: reg_d.pdown = reg_d.pdown;
      endcase
    end
    reg_d.flg_a[UBSC_IDLE_FLAG_BIT] = reg_d.flg_a[UBSC_IDLE_FLAG_BIT] | ev_idle;
    reg_d.flg_b[UBSC_RESET_FLAG_BIT] = reg_d.flg_b[UBSC_RESET_FLAG_BIT] | ev_reset;
    reg_d.flg_b[UBSC_WAKE_FLAG_BIT] = reg_d.flg_b[UBSC_WAKE_FLAG_BIT] | ev_wake;
    // Wake clears a power-down already set, even against a same-cycle write; it does not stop a write that first sets it
    if (reg_q.pdown && (irq_any || ev_reset || ev_wake)) begin
      reg_d.pdown = 1'b0;
    end
    if (i_rd) begin
      unique case (i_addr)
        UBSC_ENADR_OFS: reg_d.rdata = reg_q.enadr;
        UBSC_FLGA_OFS: reg_d.rdata = reg_q.flg_a;
        UBSC_FLGB_OFS: reg_d.rdata = reg_q.flg_b;
        UBSC_CFG_OFS: reg_d.rdata = reg_q.cfg;
        UBSC_MSKA_OFS: reg_d.rdata = reg_q.msk_a;
        UBSC_MSKB_OFS: reg_d.rdata = reg_q.msk_b;
        UBSC_PDOWN_OFS: reg_d.rdata = {7'h00, reg_q.pdown};
        default: reg_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_q <= '{enadr: UBSC_REG_RST, flg_a: UBSC_REG_RST, flg_b: UBSC_REG_RST, cfg: UBSC_REG_RST,
        msk_a: UBSC_REG_RST, msk_b: UBSC_REG_RST, pdown: 1'b0, st: UBSC_DEV_ACTIVE,
        se0_cnt: 32'h0, idle_cnt: 32'h0, k_cnt: 32'h0, rst_seen: 1'b0, rdata: 8'h00};
    end else if (i_clk_en) begin
      reg_q <= reg_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.dev_dp_o = 1'b0;
  assign link.dev_dm_o = 1'b1;
  assign link.dev_dp_oe = drive_wake;
  assign link.dev_dm_oe = drive_wake;
  assign link.dev_pullup_en = reg_q.cfg[UBSC_PULLUP_BIT];
  assign o_rdata = reg_q.rdata;
  assign o_irq = irq_any;
  assign o_cpu_power_down = reg_q.pdown;
  assign o_function_active = reg_q.enadr[UBSC_FUNC_EN_BIT];
  assign o_suspended = reg_q.st == UBSC_DEV_SUSPENDED;
  assign o_low_power = reg_q.enadr[UBSC_FUNC_EN_BIT] && reg_q.cfg[UBSC_LOW_POWER_BIT];
  assign o_device_address = reg_q.enadr[6:0];
endmodule : ubsc_device

// ===== core/ubsc_host.sv
// Purpose: Host-side bus-state driver: keep-alive, bus reset, suspend, resume.
// Assumes: Same core clock as the device end.
// Notes: Keep-alive is a short SE0 each frame time, standing in for frame traffic.
`timescale 1ns/10ps
module ubsc_host
  import ubsc_pkg::*;
#(
  parameter int unsigned HOST_RESET_CYC = UBSC_HOST_RESET_CYC,
  parameter int unsigned HOST_RESUME_CYC = UBSC_HOST_RESUME_CYC,
  parameter int unsigned KEEPALIVE_CYC = UBSC_KEEPALIVE_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  ubsc_link_if.host link,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ubsc_host_state_t st;
    logic [31:0] cnt;
    logic [1:0] evt;
    logic [1:0] msk;
    logic [7:0] rdata;
    logic idle_pend;
  } ubsc_host_regs_t;

  ubsc_host_regs_t reg_q;
  ubsc_host_regs_t reg_d;
  logic cmd_wr;
  logic drv_se0;
  logic drv_k;
  logic ev_rwake;
  logic ev_done;

  assign cmd_wr = i_wr && (i_addr == UBSC_HCMD_OFS);
  assign drv_se0 = (reg_q.st == UBSC_H_RESET) ||
    ((reg_q.st == UBSC_H_RUN) && (reg_q.cnt >= KEEPALIVE_CYC - UBSC_EOP_CYC));
  assign drv_k = reg_q.st == UBSC_H_RESUME;

  always_comb begin
    reg_d = reg_q;
    ev_rwake = 1'b0;
    ev_done = 1'b0;
    reg_d.rdata = 8'h00;
    reg_d.cnt = reg_q.cnt + 32'h1;
    unique case (reg_q.st)
      UBSC_H_RUN: begin
        if (reg_q.cnt >= KEEPALIVE_CYC - 32'h1) begin
          reg_d.cnt = 32'h0;
        end
        if (cmd_wr && i_wdata[UBSC_HCMD_RESET_BIT]) begin
          reg_d.st = UBSC_H_RESET;
          reg_d.cnt = 32'h0;
          reg_d.idle_pend = 1'b0;
        end else if ((cmd_wr && i_wdata[UBSC_HCMD_SUSPEND_BIT]) || reg_q.idle_pend) begin
          // A keepalive SE0 is never cut short; the bus goes quiet once it has run its course
          if (drv_se0 && (reg_q.cnt < KEEPALIVE_CYC - 32'h1)) begin
            reg_d.idle_pend = 1'b1;
          end else begin
            reg_d.st = UBSC_H_QUIET;
            reg_d.cnt = 32'h0;
            reg_d.idle_pend = 1'b0;
          end
        end
      end
      UBSC_H_RESET: begin
        if (reg_q.cnt >= HOST_RESET_CYC - 32'h1) begin
          reg_d.st = UBSC_H_RUN;
          reg_d.cnt = 32'h0;
          ev_done = 1'b1;
        end
      end
      UBSC_H_QUIET: begin
        reg_d.cnt = 32'h0;
        if (cmd_wr && i_wdata[UBSC_HCMD_RESET_BIT]) begin
          reg_d.st = UBSC_H_RESET;
        end else if (cmd_wr && i_wdata[UBSC_HCMD_RESUME_BIT]) begin
          reg_d.st = UBSC_H_RESUME;
        end else if (!link.dp_line && link.dm_line) begin
          // Device remote wake: answer with our own resume
          ev_rwake = 1'b1;
          reg_d.st = UBSC_H_RESUME;
        end
      end
      UBSC_H_RESUME: begin
        if (reg_q.cnt >= HOST_RESUME_CYC - 32'h1) begin
          reg_d.st = UBSC_H_RUN;
          reg_d.cnt = 32'h0;
          ev_done = 1'b1;
        end
      end
    endcase
    // Write-one-to-clear; a same-cycle event wins
    if (i_wr && (i_addr == UBSC_HEVT_OFS)) begin
      reg_d.evt = reg_q.evt & ~i_wdata[1:0];
    end
    if (i_wr && (i_addr == UBSC_HMSK_OFS)) begin
      reg_d.msk = i_wdata[1:0];
    end
    reg_d.evt[UBSC_HEVT_RWAKE_BIT] = reg_d.evt[UBSC_HEVT_RWAKE_BIT] | ev_rwake;
    reg_d.evt[UBSC_HEVT_DONE_BIT] = reg_d.evt[UBSC_HEVT_DONE_BIT] | ev_done;
    if (i_rd) begin
      unique case (i_addr)
        UBSC_HSTAT_OFS: reg_d.rdata = {5'h00, link.dp_line && !link.dm_line, reg_q.st == UBSC_H_QUIET,
          drv_se0 && (reg_q.st == UBSC_H_RESET) || drv_k};
        UBSC_HEVT_OFS: reg_d.rdata = {6'h00, reg_q.evt};
        UBSC_HMSK_OFS: reg_d.rdata = {6'h00, reg_q.msk};
        default: reg_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_q <= '{st: UBSC_H_RUN, cnt: 32'h0, evt: 2'h0, msk: 2'h0, rdata: 8'h00, idle_pend: 1'b0};
    end else if (i_clk_en) begin
      reg_q <= reg_d;
    end
  end

  // ****************************************
  // Line drive
  // ****************************************
  assign link.host_dp_o = 1'b0;
  assign link.host_dm_o = drv_k;
  assign link.host_dp_oe = drv_se0 || drv_k;
  assign link.host_dm_oe = drv_se0 || drv_k;
  assign o_rdata = reg_q.rdata;
  assign o_irq = |(reg_q.evt & reg_q.msk);
endmodule : ubsc_host

// ===== test/ubsc_link_sva.sv
// Purpose: Wire checks on the link between the host and device ends.
// Assumes: One clock; only link lines, clock and reset are seen.
// Notes: Run lengths are counted in helper registers.
`timescale 1ns/10ps
module ubsc_link_sva #(
  parameter int unsigned HOST_RESET_CYC = 80,
  parameter int unsigned HOST_RESUME_CYC = 40,
  parameter int unsigned SUSPEND_IDLE_CYC = 100
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic host_dp_o,
  input wire logic host_dp_oe,
  input wire logic host_dm_o,
  input wire logic host_dm_oe,
  input wire logic dev_dp_o,
  input wire logic dev_dp_oe,
  input wire logic dev_dm_o,
  input wire logic dev_dm_oe,
  input wire logic dev_pullup_en,
  input wire logic dp_line,
  input wire logic dm_line
);
  // ****************************************
  // Run-length helpers
  // ****************************************
  logic host_se0;
  logic host_k;
  logic [31:0] se0_len_q;
  logic [31:0] k_len_q;
  logic [31:0] j_len_q;
  logic idle_seen_q;
  assign host_se0 = host_dp_oe && host_dm_oe && !host_dp_o && !host_dm_o;
  assign host_k = host_dp_oe && !host_dp_o && host_dm_o;
  // Idle is forgotten once the host drives, so a late remote wake is not excused
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      se0_len_q <= 32'h0;
      k_len_q <= 32'h0;
      j_len_q <= 32'h0;
      idle_seen_q <= 1'b0;
    end else begin
      se0_len_q <= host_se0 ? se0_len_q + 32'h1 : 32'h0;
      k_len_q <= host_k ? k_len_q + 32'h1 : 32'h0;
      j_len_q <= (dp_line && !dm_line) ? j_len_q + 32'h1 : 32'h0;
      if (host_dp_oe) idle_seen_q <= 1'b0;
      else if (j_len_q >= SUSPEND_IDLE_CYC) idle_seen_q <= 1'b1;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  a_dev_k_level: assert property (dev_dp_oe |-> !dev_dp_o && dev_dm_o)
    else $error("device drive is not K");
  a_dev_oe_paired: assert property (dev_dp_oe == dev_dm_oe)
    else $error("device line enables differ");
  a_wake_after_idle: assert property ($rose(dev_dp_oe) |-> idle_seen_q && !host_dp_oe)
    else $error("device drove before bus idle");
  a_host_answers_wake: assert property ($rose(dev_dp_oe) |-> ##[1:3] host_k)
    else $error("host did not resume after wake");
  a_host_se0_min: assert property ($rose(host_se0) |-> host_se0 [*2])
    else $error("host SE0 shorter than two cycles");
  a_host_se0_len: assert property ($fell(host_se0) |-> se0_len_q == 32'h2 || se0_len_q >= HOST_RESET_CYC)
    else $error("host SE0 length wrong");
  a_host_resume_len: assert property ($fell(host_k) |-> k_len_q >= HOST_RESUME_CYC)
    else $error("host resume too short");
  a_host_dp_low: assert property (host_dp_oe |-> !host_dp_o && host_dm_oe)
    else $error("host drive not SE0 or K");
  c_bus_reset: cover property ($fell(host_se0) && se0_len_q >= HOST_RESET_CYC);
  c_remote_wake: cover property ($rose(dev_dp_oe));
  c_host_resume: cover property ($fell(host_k));
endmodule : ubsc_link_sva

// ===== test/usb_bus_state_control_tb_top.sv
// Purpose: Drives both register ports and checks bus-state behaviour end to end.
// Assumes: Shortened counts; clock enable low only in the freeze scenario at the end.
// Notes: Address and write data are shared by the two register ports.
`timescale 1ns/10ps
module usb_bus_state_control_tb_top;
  import ubsc_pkg::*;
  localparam int unsigned BR = 50;
  localparam int unsigned SI = 100;
  localparam int unsigned RD = 5;
  localparam int unsigned HR = 80;
  localparam int unsigned HS = 40;
  localparam int unsigned KA = 30;
  localparam int LIMIT = 20000;
  logic i_core_clk;
  logic i_resetn;
  logic clk_en;
  logic [7:0] b_addr;
  logic [7:0] b_wdata;
  logic [7:0] d_rdata;
  logic [7:0] h_rdata;
  logic d_wr, d_rd, h_wr, h_rd;
  logic d_irq, h_irq, d_pdown, d_active, d_suspended, d_lowp;
  logic [6:0] d_dev_addr;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // Port pins stay floating: only the host pull-downs and the DP pull-up act on idle lines
  ubsc_link_if link();
  ubsc_device #(.BUS_RESET_CYC(BR), .SUSPEND_IDLE_CYC(SI), .RESUME_DETECT_CYC(RD)) i_ubsc_device (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(clk_en), .link(link.dev), .i_addr(b_addr),
    .i_wdata(b_wdata), .i_wr(d_wr), .i_rd(d_rd), .o_rdata(d_rdata), .o_irq(d_irq), .o_cpu_power_down(d_pdown),
    .o_function_active(d_active), .o_suspended(d_suspended), .o_low_power(d_lowp), .o_device_address(d_dev_addr));
  ubsc_host #(.HOST_RESET_CYC(HR), .HOST_RESUME_CYC(HS), .KEEPALIVE_CYC(KA)) i_ubsc_host (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(clk_en), .link(link.host), .i_addr(b_addr),
    .i_wdata(b_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata), .o_irq(h_irq));
  ubsc_link_sva #(.HOST_RESET_CYC(HR), .HOST_RESUME_CYC(HS), .SUSPEND_IDLE_CYC(SI)) i_ubsc_link_sva (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .host_dp_o(link.host_dp_o), .host_dp_oe(link.host_dp_oe),
    .host_dm_o(link.host_dm_o), .host_dm_oe(link.host_dm_oe), .dev_dp_o(link.dev_dp_o), .dev_dp_oe(link.dev_dp_oe),
    .dev_dm_o(link.dev_dm_o), .dev_dm_oe(link.dev_dm_oe), .dev_pullup_en(link.dev_pullup_en),
    .dp_line(link.dp_line), .dm_line(link.dm_line));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cycles(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : cycles
  task automatic wr(input bit h, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    b_addr <= a;
    b_wdata <= d;
    if (h) h_wr <= 1'b1;
    else d_wr <= 1'b1;
    @(posedge i_core_clk);
    h_wr <= 1'b0;
    d_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input bit h, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    b_addr <= a;
    if (h) h_rd <= 1'b1;
    else d_rd <= 1'b1;
    @(posedge i_core_clk);
    h_rd <= 1'b0;
    d_rd <= 1'b0;
    #1;
    chk(h ? h_rdata : d_rdata, e);
  endtask : rd
  // Last keepalive may fall up to one frame before the command, so the idle count starts early
  task automatic go_suspend();
    int k;
    wr(1'b1, UBSC_HCMD_OFS, 8'h02);
    k = 0;
    while (d_suspended !== 1'b1 && k < 300) begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    chk({7'h0, k >= SI - KA - 5 && k <= SI + 4}, 8'h01);
  endtask : go_suspend
  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    i_resetn = 1'b0;
    clk_en = 1'b1;
    b_addr = 8'h00;
    b_wdata = 8'h00;
    d_wr = 1'b0;
    d_rd = 1'b0;
    h_wr = 1'b0;
    h_rd = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    for (int a = 16; a < 23; a++) rd(1'b0, 8'(a), UBSC_REG_RST);
    rd(1'b0, 8'h20, 8'h00);
    rd(1'b1, UBSC_HEVT_OFS, 8'h00);
    // Pull-up off leaves the line in SE0
    cycles(60);
    rd(1'b0, UBSC_FLGB_OFS, 8'h00);
    wr(1'b0, UBSC_ENADR_OFS, 8'h85);
    rd(1'b0, UBSC_ENADR_OFS, 8'h85);
    chk({d_active, d_dev_addr}, 8'h85);
    cycles(60);
    rd(1'b0, UBSC_FLGB_OFS, 8'h10);
    wr(1'b0, UBSC_MSKB_OFS, 8'h10);
    chk({7'h0, d_irq}, 8'h01);
    wr(1'b0, UBSC_FLGB_OFS, 8'hff);
    rd(1'b0, UBSC_FLGB_OFS, 8'h10);
    wr(1'b0, UBSC_FLGB_OFS, 8'h08);
    rd(1'b0, UBSC_FLGB_OFS, 8'h00);
    chk({7'h0, d_irq}, 8'h00);
    wr(1'b0, UBSC_MSKB_OFS, 8'h00);
    wr(1'b0, UBSC_CFG_OFS, 8'hff);
    rd(1'b0, UBSC_CFG_OFS, 8'hf9);
    chk({6'h0, link.dev_pullup_en, d_lowp}, 8'h03);
    wr(1'b0, UBSC_CFG_OFS, 8'h08);
    chk({6'h0, link.dev_pullup_en, d_lowp}, 8'h02);
    cycles(150);
    rd(1'b0, UBSC_FLGA_OFS, 8'h00);
    wr(1'b1, UBSC_HMSK_OFS, 8'h03);
    go_suspend();
    rd(1'b0, UBSC_FLGA_OFS, 8'h04);
    rd(1'b1, UBSC_HSTAT_OFS, 8'h06);
    wr(1'b0, UBSC_PDOWN_OFS, 8'h01);
    rd(1'b0, UBSC_PDOWN_OFS, 8'h01);
    wr(1'b0, UBSC_MSKA_OFS, 8'h04);
    chk({7'h0, d_irq}, 8'h01);
    cycles(1);
    chk({7'h0, d_pdown}, 8'h00);
    wr(1'b0, UBSC_MSKA_OFS, 8'h00);
    wr(1'b0, UBSC_FLGA_OFS, 8'h00);
    rd(1'b0, UBSC_FLGA_OFS, 8'h00);
    wr(1'b0, UBSC_PDOWN_OFS, 8'h01);
    wr(1'b0, UBSC_CFG_OFS, 8'h48);
    cycles(5);
    chk({7'h0, link.dev_dp_oe}, 8'h00);
    wr(1'b0, UBSC_CFG_OFS, 8'hc8);
    cycles(5);
    chk({7'h0, d_lowp}, 8'h01);
    rd(1'b1, UBSC_HEVT_OFS, 8'h01);
    wr(1'b0, UBSC_CFG_OFS, 8'h08);
    cycles(RD + 4);
    chk({6'h0, d_suspended, d_pdown}, 8'h00);
    rd(1'b0, UBSC_FLGB_OFS, 8'h08);
    cycles(HS);
    rd(1'b1, UBSC_HEVT_OFS, 8'h03);
    chk({7'h0, h_irq}, 8'h01);
    wr(1'b1, UBSC_HEVT_OFS, 8'h03);
    rd(1'b1, UBSC_HEVT_OFS, 8'h00);
    wr(1'b0, UBSC_FLGB_OFS, 8'h00);
    go_suspend();
    wr(1'b0, UBSC_PDOWN_OFS, 8'h01);
    wr(1'b1, UBSC_HCMD_OFS, 8'h01);
    cycles(HR + 5);
    chk({6'h0, d_suspended, d_pdown}, 8'h00);
    rd(1'b0, UBSC_FLGB_OFS, 8'h10);
    wr(1'b0, UBSC_FLGB_OFS, 8'h00);
    go_suspend();
    wr(1'b1, UBSC_HCMD_OFS, 8'h04);
    cycles(RD + 4);
    chk({7'h0, d_suspended}, 8'h00);
    rd(1'b0, UBSC_FLGB_OFS, 8'h08);
    wr(1'b0, UBSC_FLGB_OFS, 8'h00);
    rd(1'b0, UBSC_FLGA_OFS, 8'h04);
    // A write while the clock enable is low must not land
    @(posedge i_core_clk);
    clk_en <= 1'b0;
    wr(1'b0, UBSC_ENADR_OFS, 8'h00);
    chk({d_active, d_dev_addr}, 8'h85);
    @(posedge i_core_clk);
    clk_en <= 1'b1;
    cycles(2);
    chk({d_active, d_dev_addr}, 8'h85);
    end_sim();
  end
endmodule : usb_bus_state_control_tb_top
